// ==== src/cycio_consts.svh ====
// Constants of the cyclic IO register handshake block
`ifndef CYCIO_CONSTS_SVH
`define CYCIO_CONSTS_SVH

// ==========================================================================
// Register indices and byte addresses (byte address = 4 * index)
// ==========================================================================
`define CYCIO_IDX_RX_CONN     16'h03E8
`define CYCIO_IDX_RX_IOCTL    16'h03E9
`define CYCIO_IDX_RX_DATA0    16'h03EA
`define CYCIO_IDX_RX_DATA1    16'h03EB
`define CYCIO_IDX_TX_CONN     16'h07D0
`define CYCIO_IDX_TX_IOSTAT   16'h07D1
`define CYCIO_IDX_TX_DATA0    16'h07D2
`define CYCIO_IDX_TX_DATA1    16'h07D3
`define CYCIO_ADDR_RX_CONN    16'h0FA0
`define CYCIO_ADDR_RX_IOCTL   16'h0FA4
`define CYCIO_ADDR_RX_DATA0   16'h0FA8
`define CYCIO_ADDR_RX_DATA1   16'h0FAC
`define CYCIO_ADDR_TX_CONN    16'h1F40
`define CYCIO_ADDR_TX_IOSTAT  16'h1F44
`define CYCIO_ADDR_TX_DATA0   16'h1F48
`define CYCIO_ADDR_TX_DATA1   16'h1F4C
`define CYCIO_ADDR_CTRL       16'h0000
`define CYCIO_ADDR_IRQ_STAT   16'h0004
`define CYCIO_ADDR_IRQ_MASK   16'h0008
`define CYCIO_ADDR_PHASE      16'h000C

// ==========================================================================
// Field positions and values
// ==========================================================================
`define CYCIO_CC_PRODUCER     0
`define CYCIO_CC_FRESH        1
`define CYCIO_CC_SYNC         3
`define CYCIO_CC_FRESH_COPY   12
`define CYCIO_IOS_OUT_READY   15
`define CYCIO_IOS_IN_VALID    14
`define CYCIO_CTRL_COMPAT     0
`define CYCIO_IRQ_RX          0
`define CYCIO_IRQ_TX          1
`define CYCIO_IRQ_PHASE       2
`define CYCIO_IRQ_W           3
`define CYCIO_HALF_W          16
`define CYCIO_DATA_W          32
`define CYCIO_ADDR_LSB        2
`define CYCIO_ADDR_MSB        15
`define CYCIO_RST_HALF        16'h0000
`define CYCIO_RST_WORD        32'h0000_0000
`define CYCIO_RST_IRQ         3'h0
`define CYCIO_HTRANS_NONSEQ   2'h2
`define CYCIO_HTRANS_SEQ      2'h3
`define CYCIO_HSIZE_WORD      3'h2

`endif

// ==== src/cycio_pkg.sv ====
// Types shared by the cyclic IO register handshake block
package cycio_pkg;

  // ========================================================================
  // Telegram carriers
  // ========================================================================
  typedef struct packed {
    logic        producer_ready; // Master declares its data valid
    logic [15:0] io_control;     // Received IO-control word
    logic [63:0] payload;        // Received input area, two words
  } cycio_mdt_s;

  typedef struct packed {
    logic [15:0] conn_ctrl;      // Outgoing connection-control word
    logic [15:0] io_status;      // Outgoing IO-status word
    logic [63:0] payload;        // Outgoing output area, two words
  } cycio_at_s;

  // ========================================================================
  // Bus data-phase states
  // ========================================================================
  typedef enum logic [1:0] {
    CYCIO_DP_IDLE  = 2'b00,
    CYCIO_DP_WRITE = 2'b01,
    CYCIO_DP_RWAIT = 2'b10,
    CYCIO_DP_RDONE = 2'b11
  } cycio_dp_e;

endpackage

// ==== src/cycio_sync3.sv ====
// Three-stage synchroniser with agreement filter for one pin level
`timescale 1ns/1ps
module cycio_sync3 (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output      logic level
);
  logic s1_reg; // First stage, read only by s2
  logic s2_reg; // Second stage
  logic s3_reg; // Third stage

  // ========================================================================
  // Shift chain; the level moves only when stages two and three agree
  // ========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level  <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin // Filters a one-cycle glitch
        level <= s3_reg;
      end
    end
  end
endmodule

// ==== src/cycio_fresh.sv ====
// Fresh-data flag: cleared on phase entry, toggled on each new-data event
`timescale 1ns/1ps
module cycio_fresh (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clear,
  input  wire logic toggle,
  output      logic flag
);
  // ========================================================================
  // Phase entry wins over a toggle in the same cycle
  // ========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (clear) begin
      flag <= 1'b0;
    end else if (toggle) begin
      flag <= ~flag;  // Each change announces new data
    end
  end
endmodule

// ==== src/cycio_top.sv ====
// AHB-Lite register bank for the cyclic IO exchange of the fieldbus slave
`timescale 1ns/1ps
`include "cycio_consts.svh"
module cycio_top
  import cycio_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic        hreadyout,
  output      logic        hresp,
  output      logic [31:0] hrdata,
  // Protocol engine side
  input  wire logic        phase_pin,
  input  wire logic        mdt_valid,
  input  wire cycio_mdt_s  mdt_in,
  input  wire logic        at_strobe,
  output      cycio_at_s   at_out,
  output      logic        irq
);

  // ========================================================================
  // Declarations
  // ========================================================================
  cycio_dp_e   dp_reg;          // Data-phase state
  cycio_dp_e   dp_next;         // Its next value
  logic [`CYCIO_ADDR_MSB:0] addr_reg; // Latched byte address
  logic        hreadyout_reg;   // Bus ready, from a flop
  logic [31:0] hrdata_reg;      // Read data, from a flop

  logic        phase;           // Cyclic phase level after sync
  logic        phase_d_reg;     // Previous phase level
  logic        phase_enter;     // Pulse on phase entry
  logic        rx_fresh;        // Received fresh-data flag
  logic        tx_fresh;        // Outgoing fresh-data flag
  logic        tx_toggle;       // Outgoing toggle event

  logic        rx_pr_reg;       // Latched master producer-ready
  logic [15:0] rx_ioctl_reg;    // Latched IO-control word
  logic [31:0] rx_data0_reg;    // Input area word 0
  logic [31:0] rx_data1_reg;    // Input area word 1
  logic        tx_pr_reg;       // Host producer-ready
  logic [15:0] tx_iostat_reg;   // Host IO-status word
  logic [31:0] tx_data0_reg;    // Output area word 0
  logic [31:0] tx_data1_reg;    // Output area word 1
  logic        dirty_reg;       // Host changed outgoing data since last send
  logic        compat_reg;      // Hides bits 3 and 12 when set

  logic [`CYCIO_IRQ_W-1:0] irq_stat_reg; // Sticky events
  logic [`CYCIO_IRQ_W-1:0] irq_mask_reg; // Enables
  logic [`CYCIO_IRQ_W-1:0] irq_event;    // Events this cycle
  logic        irq_reg;         // Interrupt output flop
  cycio_at_s   at_reg;          // Outgoing telegram flop

  // ========================================================================
  // Address phase decode
  // ========================================================================
  wire         addr_take  = hsel && hready && (htrans == `CYCIO_HTRANS_NONSEQ || htrans == `CYCIO_HTRANS_SEQ);
  wire         take_write = addr_take && hwrite && (hsize == `CYCIO_HSIZE_WORD);
  wire         take_read  = addr_take && !hwrite;
  wire         wr_en      = (dp_reg == CYCIO_DP_WRITE);
  wire         rd_sample  = (dp_reg == CYCIO_DP_RWAIT);

  // The next address phase overlaps this
  // data phase, hence the latched address
  // Data-phase register selects on the latched address
  wire sel_rx_conn   = (addr_reg == `CYCIO_ADDR_RX_CONN);
  wire sel_rx_ioctl  = (addr_reg == `CYCIO_ADDR_RX_IOCTL);
  wire sel_rx_data0  = (addr_reg == `CYCIO_ADDR_RX_DATA0);
  wire sel_rx_data1  = (addr_reg == `CYCIO_ADDR_RX_DATA1);
  wire sel_tx_conn   = (addr_reg == `CYCIO_ADDR_TX_CONN);
  wire sel_tx_iostat = (addr_reg == `CYCIO_ADDR_TX_IOSTAT);
  wire sel_tx_data0  = (addr_reg == `CYCIO_ADDR_TX_DATA0);
  wire sel_tx_data1  = (addr_reg == `CYCIO_ADDR_TX_DATA1);
  wire sel_ctrl      = (addr_reg == `CYCIO_ADDR_CTRL);
  wire sel_irq_stat  = (addr_reg == `CYCIO_ADDR_IRQ_STAT);
  wire sel_irq_mask  = (addr_reg == `CYCIO_ADDR_IRQ_MASK);
  wire sel_phase     = (addr_reg == `CYCIO_ADDR_PHASE);

  // ========================================================================
  // Connection-control words as software and the link see them
  // ========================================================================
  // Plain view hides bit 3 and the bit 12
  // copy; bit 1 itself is never hidden
  wire rx_pr_view = rx_pr_reg && phase;
  wire sync_bit   = !compat_reg;
  wire rx_copy    = rx_fresh && !compat_reg;
  wire tx_copy    = tx_fresh && !compat_reg;

  // Compat mode gives plain 0x0001/0x0003 words in full operation
  wire [15:0] rx_conn_word = {3'h0, rx_copy, 8'h00, sync_bit, 1'b0, rx_fresh, rx_pr_view};
  wire [15:0] tx_conn_word = {3'h0, tx_copy, 8'h00, sync_bit, 1'b0, tx_fresh, tx_pr_reg};

  // ========================================================================
  // Read multiplexer; unmapped words read as zero
  // ========================================================================
  wire [31:0] rd_mux =
      sel_rx_conn   ? {16'h0000, rx_conn_word}  :
      sel_rx_ioctl  ? {16'h0000, rx_ioctl_reg}  :
      sel_rx_data0  ? rx_data0_reg              :
      sel_rx_data1  ? rx_data1_reg              :
      sel_tx_conn   ? {16'h0000, tx_conn_word}  :
      sel_tx_iostat ? {16'h0000, tx_iostat_reg} :
      sel_tx_data0  ? tx_data0_reg              :
      sel_tx_data1  ? tx_data1_reg              :
      sel_ctrl      ? {31'h0000_0000, compat_reg} :
      sel_irq_stat  ? {29'h0000_0000, irq_stat_reg} :
      sel_irq_mask  ? {29'h0000_0000, irq_mask_reg} :
      sel_phase     ? {31'h0000_0000, phase}    :
                      `CYCIO_RST_WORD;

  // ========================================================================
  // Data-phase sequencing: writes take no wait, reads one
  // ========================================================================
  // Trade-off: one read wait state buys a
  // registered hrdata off the mux path
  // Reads sample one cycle late so a preceding write is always visible
  always_comb begin
    dp_next = CYCIO_DP_IDLE;
    case (dp_reg)
      CYCIO_DP_RWAIT: begin
        dp_next = CYCIO_DP_RDONE;      // Data captured, release bus
      end
      default: begin
        if (take_read) begin
          dp_next = CYCIO_DP_RWAIT;
        end else if (take_write) begin
          dp_next = CYCIO_DP_WRITE;
        end else begin
          dp_next = CYCIO_DP_IDLE;
        end
      end
    endcase
  end

  // State and address capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_reg   <= CYCIO_DP_IDLE;
      addr_reg <= '0;
    end else begin
      dp_reg <= dp_next;
      if (addr_take) begin
        addr_reg <= haddr[`CYCIO_ADDR_MSB:0];
      end
    end
  end

  // Ready drops only for the read wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b1;
      hrdata_reg    <= `CYCIO_RST_WORD;
    end else begin
      hreadyout_reg <= (dp_next != CYCIO_DP_RWAIT);
      if (rd_sample) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // ========================================================================
  // Cyclic phase tracking
  // ========================================================================
  // Limitation: pulses under two clocks
  // are lost; the phase is a slow level
  // Phase level arrives from a pin of another domain
  cycio_sync3 u_phase_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .pin   (phase_pin),
    .level (phase)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_d_reg <= 1'b0;
    end else begin
      phase_d_reg <= phase;
    end
  end

  // Delayed level resets to the idle pin
  // level, so no false entry after reset
  assign phase_enter = phase && !phase_d_reg;

  // ========================================================================
  // Fresh-data flags for both directions
  // ========================================================================
  // A master that is not producing sends
  // no new data, so no toggle for it
  // Received flag toggles on each valid telegram of a ready master
  cycio_fresh u_rx_fresh (
    .clk    (hclk),
    .rst_n  (hresetn),
    .clear  (phase_enter),
    .toggle (mdt_valid && phase && mdt_in.producer_ready),
    .flag   (rx_fresh)
  );

  // Toggling every slot would flag stale
  // data; dirty ties it to a host update
  // Outgoing flag toggles itself when the host changed data
  assign tx_toggle = at_strobe && phase && dirty_reg;

  cycio_fresh u_tx_fresh (
    .clk    (hclk),
    .rst_n  (hresetn),
    .clear  (phase_enter),
    .toggle (tx_toggle),
    .flag   (tx_fresh)
  );

  // ========================================================================
  // Received telegram capture
  // ========================================================================
  // Words stay readable after the phase
  // drops; producer-ready marks them stale
  // Leaving the phase drops producer-ready so stale data looks invalid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_pr_reg    <= 1'b0;
      rx_ioctl_reg <= `CYCIO_RST_HALF;
      rx_data0_reg <= `CYCIO_RST_WORD;
      rx_data1_reg <= `CYCIO_RST_WORD;
    end else if (!phase) begin
      rx_pr_reg <= 1'b0;
    end else if (mdt_valid) begin
      rx_pr_reg    <= mdt_in.producer_ready;
      rx_ioctl_reg <= mdt_in.io_control;
      rx_data0_reg <= mdt_in.payload[31:0];
      rx_data1_reg <= mdt_in.payload[63:32];
    end
  end

  // ========================================================================
  // Host-written registers
  // ========================================================================
  // Writes to read-only or unmapped words
  // are dropped, still with OKAY
  // Only bit 0 of outgoing connection control is host-owned
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_pr_reg     <= 1'b0;
      tx_iostat_reg <= `CYCIO_RST_HALF;
      tx_data0_reg  <= `CYCIO_RST_WORD;
      tx_data1_reg  <= `CYCIO_RST_WORD;
      compat_reg    <= 1'b0;
      irq_mask_reg  <= `CYCIO_RST_IRQ;
    end else if (wr_en) begin
      if (sel_tx_conn) begin
        tx_pr_reg <= hwdata[`CYCIO_CC_PRODUCER];
      end
      if (sel_tx_iostat) begin
        tx_iostat_reg <= hwdata[15:0];
      end
      if (sel_tx_data0) begin
        tx_data0_reg <= hwdata;
      end
      if (sel_tx_data1) begin
        tx_data1_reg <= hwdata;
      end
      if (sel_ctrl) begin
        compat_reg <= hwdata[`CYCIO_CTRL_COMPAT];
      end
      if (sel_irq_mask) begin
        irq_mask_reg <= hwdata[`CYCIO_IRQ_W-1:0];
      end
    end
  end

  // Status writes count too, since the
  // master must see flag changes as news
  // Dirty marks fresh payload; a write in the send cycle is kept
  wire host_change = wr_en && (sel_tx_data0 || sel_tx_data1 || sel_tx_iostat);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dirty_reg <= 1'b0;
    end else if (host_change) begin
      dirty_reg <= 1'b1;            // Set wins over the send
    end else if (tx_toggle || phase_enter) begin
      dirty_reg <= 1'b0;
    end
  end

  // ========================================================================
  // Outgoing telegram
  // ========================================================================
  // One snapshot per slot, so payload and
  // status never mix two host updates
  // Carries the flag value after this send's toggle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      at_reg <= '0;
    end else if (at_strobe) begin
      at_reg.conn_ctrl <= {3'h0, tx_copy ^ (tx_toggle && !compat_reg), 8'h00,
                           sync_bit, 1'b0, tx_fresh ^ tx_toggle, tx_pr_reg};
      at_reg.io_status <= tx_iostat_reg;
      at_reg.payload   <= {tx_data1_reg, tx_data0_reg};
    end
  end

  // ========================================================================
  // Interrupts: sticky status, read clears, set wins
  // ========================================================================
  assign irq_event[`CYCIO_IRQ_RX]    = mdt_valid && phase;
  assign irq_event[`CYCIO_IRQ_TX]    = tx_toggle;
  assign irq_event[`CYCIO_IRQ_PHASE] = phase_enter;

  wire stat_clear = rd_sample && sel_irq_stat;

  // The flop sees the same next status, so
  // irq moves on the same edge as the sticky bits

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_reg <= `CYCIO_RST_IRQ;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= (stat_clear ? `CYCIO_RST_IRQ : irq_stat_reg) | irq_event;
      irq_reg      <= |(((stat_clear ? `CYCIO_RST_IRQ : irq_stat_reg) | irq_event) & irq_mask_reg);
    end
  end

  // ========================================================================
  // Outputs, all straight from flops except hresp, tied to OKAY
  // ========================================================================
  assign hreadyout = hreadyout_reg;
  // No transfer is ever refused
  assign hresp     = 1'b0;          // Always OKAY
  assign hrdata    = hrdata_reg;
  assign at_out    = at_reg;
  assign irq       = irq_reg;

endmodule

// ==== verification/cycio_checker.sv ====
// Checker for the cyclic IO register bank, bound to its top module
`timescale 1ns/1ps
`include "cycio_consts.svh"
module cycio_checker
  import cycio_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        phase_pin,
  input wire logic        at_strobe,
  input wire cycio_at_s   at_out,
  input wire logic        irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ==========================================================================
  // Helper decode
  // ==========================================================================
  wire        acc    = hsel && hready && htrans[1];          // Any accepted transfer
  wire        rd_acc = acc && !hwrite;                       // Accepted read
  wire        rx_rd  = rd_acc && (haddr[15:0] == `CYCIO_ADDR_RX_CONN);
  logic [3:0] low_cnt;                                       // Phase-low run length

  // Saturating count, so the synchroniser delay is long past
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt <= 4'h0;
    end else if (phase_pin) begin
      low_cnt <= 4'h0;
    end else if (low_cnt != 4'hF) begin
      low_cnt <= low_cnt + 4'h1;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not OKAY");
  a_read_wait: assert property (rd_acc |=> !hreadyout ##1 hreadyout)
    else $error("read wait cycle wrong");
  a_write_zero: assert property (acc && hwrite |=> hreadyout)
    else $error("write inserted a wait");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_acc, 2))
    else $error("read data changed without a read");
  a_tel_hold: assert property (!at_strobe |=> $stable(at_out))
    else $error("telegram changed without strobe");
  a_fresh_mirror: assert property (at_out.conn_ctrl[1] == at_out.conn_ctrl[12])
    else $error("fresh copy differs");
  a_sync_bit: assert property (at_strobe |=> at_out.conn_ctrl[3])
    else $error("sync bit not set");
  a_rx_ready: assert property (rx_rd && (low_cnt > 4'h6) |-> ##2 !hrdata[0])
    else $error("producer ready outside phase");

  c_read: cover property (rd_acc ##2 hreadyout);
  c_toggle: cover property (at_strobe ##1 $changed(at_out.conn_ctrl[1]));
  c_irq: cover property ($rose(irq));
endmodule

bind cycio_top cycio_checker chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .phase_pin, .at_strobe, .at_out, .irq);

// ==== verification/cycio_engine_model.sv ====
// Model of the fieldbus protocol engine feeding the register bank
`timescale 1ns/1ps
module cycio_engine_model
  import cycio_pkg::*;
(
  input  wire logic clk,
  output logic       mdt_valid,
  output cycio_mdt_s mdt_in,
  output logic       at_strobe
);
  // Quiet link at start
  initial begin
    mdt_valid = 1'b0;
    at_strobe = 1'b0;
    mdt_in    = '0;
  end

  // One received telegram; lines scramble once it is gone
  task automatic send_mdt(input logic pr, input logic [15:0] ioc, input logic [63:0] pl);
    @(posedge clk);
    mdt_valid <= 1'b1;
    mdt_in    <= {pr, ioc, pl};
    @(posedge clk);
    mdt_valid <= 1'b0;
    mdt_in    <= ~{pr, ioc, pl};
  endtask

  // One send slot of the outgoing telegram
  task automatic send_at();
    @(posedge clk);
    at_strobe <= 1'b1;
    @(posedge clk);
    at_strobe <= 1'b0;
  endtask
endmodule

// ==== verification/cycio_top_test.sv ====
// Self-checking bench for the cyclic IO register bank
`timescale 1ns/1ps
`include "cycio_consts.svh"
module cycio_top_test;
  import cycio_pkg::*;

  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        hclk      = 1'b0;
  logic        hresetn   = 1'b0;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0000_0000;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [2:0]  hsize     = 3'h0;
  logic [31:0] hwdata    = 32'h0000_0000;
  logic        phase_pin = 1'b0;
  wire         hready;
  wire         hreadyout, hresp, mdt_valid, at_strobe, irq;
  wire [31:0]  hrdata;
  cycio_mdt_s  mdt_in;
  cycio_at_s   at_out;
  int          fail_count = 0;                 // Mismatches
  int          n_tests    = 0;                 // Comparisons
  integer      seed       = 32'hAEAC7B81;      // Fixed seed, repeatable run
  logic [31:0] rd_q[$];                        // Expected read data
  logic [95:0] at_q[$];                        // Expected telegrams
  logic        rd_pend    = 1'b0;              // Read data phase open
  logic        at_seen    = 1'b0;              // Strobe seen last edge
  logic [31:0] d0, d1;                         // Payload words

  assign hready = hreadyout;                   // Single slave owns hready
  always #10 hclk = ~hclk;

  cycio_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .phase_pin, .mdt_valid, .mdt_in, .at_strobe, .at_out, .irq);
  cycio_engine_model eng_u (.clk(hclk), .mdt_valid, .mdt_in, .at_strobe);

  // ==========================================================================
  // Compare, bus and closing tasks
  // ==========================================================================
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_tel(input logic [95:0] got, input logic [95:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Single word transfer; waits on hready, never on a fixed count
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= `CYCIO_HTRANS_NONSEQ;
    haddr  <= {16'h0000, a};
    hwrite <= wr;
    hsize  <= `CYCIO_HSIZE_WORD;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // Strobe a send slot and note the telegram that must leave
  task automatic tx(input logic [15:0] c, input logic [15:0] s);
    at_q.push_back({c, s, d1, d0});
    eng_u.send_at();
  endtask

  task automatic chk_irq(input logic e);
    #1 cmp_word({31'h0, irq}, {31'h0, e});
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Monitor: takes the oldest note whenever a result shows
  // ==========================================================================
  always @(posedge hclk) begin
    if (rd_pend && hready) begin
      cmp_word(hrdata, rd_q.pop_front());
      rd_pend <= 1'b0;
    end
    if (hsel && hready && htrans[1] && !hwrite) begin
      rd_pend <= 1'b1;
    end
    if (at_seen) begin
      cmp_tel(at_out, at_q.pop_front());
    end
    at_seen <= at_strobe;
  end

  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #400000;
    fail_count++;
    summarize();
  end

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`CYCIO_ADDR_IRQ_MASK, 32'h0);
    // Telegram outside the phase must not land
    eng_u.send_mdt(1'b1, 16'h8000, {$random(seed), $random(seed)});
    rd(`CYCIO_ADDR_RX_CONN, 32'h0000_0008);
    rd(16'h0100, 32'h0);
    phase_pin <= 1'b1;
    repeat (10) @(posedge hclk);
    chk_irq(1'b0);
    rd(`CYCIO_ADDR_PHASE, 32'h1);
    rd(`CYCIO_ADDR_IRQ_STAT, 32'h4);
    rd(`CYCIO_ADDR_IRQ_STAT, 32'h0);
    // Received telegrams, valid then invalid
    d0 = $random(seed);
    d1 = $random(seed);
    eng_u.send_mdt(1'b1, 16'h8000, {d1, d0});
    rd(`CYCIO_ADDR_RX_CONN, 32'h100B);
    rd(`CYCIO_ADDR_RX_IOCTL, 32'h8000);
    rd(`CYCIO_ADDR_RX_DATA0, d0);
    rd(`CYCIO_ADDR_RX_DATA1, d1);
    wr(`CYCIO_ADDR_RX_IOCTL, 32'h0);
    rd(`CYCIO_ADDR_RX_IOCTL, 32'h8000);
    eng_u.send_mdt(1'b0, 16'h0000, {d0, d1});
    rd(`CYCIO_ADDR_RX_CONN, 32'h100A);
    // Host fills the output side, then slots go out
    d0 = $random(seed);
    d1 = $random(seed);
    wr(`CYCIO_ADDR_TX_DATA0, d0);
    wr(`CYCIO_ADDR_TX_DATA1, d1);
    wr(`CYCIO_ADDR_TX_IOSTAT, 32'hC000);
    wr(`CYCIO_ADDR_TX_CONN, 32'h1);
    wr(`CYCIO_ADDR_IRQ_MASK, 32'h2);
    tx(16'h100B, 16'hC000);
    chk_irq(1'b1);
    rd(`CYCIO_ADDR_IRQ_STAT, 32'h3);
    chk_irq(1'b0);
    tx(16'h100B, 16'hC000);
    wr(`CYCIO_ADDR_TX_IOSTAT, 32'h4000);
    tx(16'h0009, 16'h4000);
    rd(`CYCIO_ADDR_TX_CONN, 32'h0000_0009);
    rd(`CYCIO_ADDR_TX_IOSTAT, 32'h4000);
    rd(`CYCIO_ADDR_TX_DATA1, d1);
    wr(`CYCIO_ADDR_TX_CONN, 32'h0);
    rd(`CYCIO_ADDR_TX_CONN, 32'h0000_0008);
    wr(`CYCIO_ADDR_TX_CONN, 32'h1);
    wr(`CYCIO_ADDR_TX_IOSTAT, 32'hC000);
    tx(16'h100B, 16'hC000);
    // Plain view, then a fresh phase entry clears both flags
    wr(`CYCIO_ADDR_CTRL, 32'h1);
    rd(`CYCIO_ADDR_TX_CONN, 32'h3);
    phase_pin <= 1'b0;
    repeat (10) @(posedge hclk);
    phase_pin <= 1'b1;
    repeat (10) @(posedge hclk);
    rd(`CYCIO_ADDR_TX_CONN, 32'h1);
    rd(`CYCIO_ADDR_RX_CONN, 32'h0);
    repeat (4) @(posedge hclk);
    summarize();
  end
endmodule
